// File: inc/ddr_init_host_params.svh
// Purpose: Offsets, field positions, reset values and counts for the host.
// Assumes: Device registers are reached over a 32-bit APB master port.
// Notes: Included by the host module, the device model and the bench.
`ifndef DDR_INIT_HOST_PARAMS_SVH
`define DDR_INIT_HOST_PARAMS_SVH

// Device register map
`define DEV_CAL_CTL 12'h000
`define DEV_PHY_CTL 12'h004
`define DEV_SLEW 12'h008
`define DEV_MEM_CFG 12'h00C
`define DEV_MEM_CFG2 12'h010
`define DEV_TIMING1 12'h014
`define DEV_TIMING2 12'h018
`define DEV_REFRESH 12'h01C
`define DEV_PRIORITY 12'h020
`define DEV_PHY_RST 12'h024

// Device fields
`define CAL_SLEEP 32'h0000_0001
`define CAL_FREEZE 32'h0000_0002
`define CAL_CLK_RESET 32'h0000_0004
`define CAL_RX_SAVE 32'h0000_0008
`define CAL_READY 32'h0000_0010
`define SLEW_PULLDOWN 32'h0000_0020
`define SLEW_LEVEL 32'h0000_0010
`define CFG_BOOT_UNLOCK 32'h0080_0000
`define CFG_TIM_UNLOCK 32'h0000_8000
`define REF_LOW_POWER 32'h8000_0000
`define REF_CLK_STOP 32'h4000_0000
`define REF_SELFREFRESH_OR_POWERDOWN_SELECT 32'h0080_0000
`define REF_INTERVAL 32'h0000_FFFF
`define PHY_SOFT_RESET 32'h0000_0400

// Own register map (APB slave)
`define REG_CTRL 6'h00
`define REG_STATUS 6'h04
`define REG_PHY_CFG 6'h08
`define REG_MEM_CFG 6'h0C
`define REG_MEM_CFG2 6'h10
`define REG_TIM1 6'h14
`define REG_TIM2 6'h18
`define REG_REF_INT 6'h1C
`define REG_PRIO 6'h20
`define PRIO_RESET 32'h0000_0020

// Control bits
`define CTRL_INIT 0
`define CTRL_STOP 1
`define CTRL_RESTART 2
`define CTRL_MDDR 3

// Timing
`define CLK_STOP_CYCLES 150
`define CAL_EDGES 2'h2

// Program entry points and ops
`define PC_INIT 6'h00
`define PC_STOP 6'h1D
`define PC_RESTART 6'h23
`define OP_WR 4'h0
`define OP_WRM 4'h1
`define OP_POLL1 4'h2
`define OP_POLL0 4'h3
`define OP_WAIT_CAL 4'h4
`define OP_WAIT_CYC 4'h5
`define OP_WAIT_PLL 4'h6
`define OP_PLL_ON 4'h7
`define OP_PLL_OFF 4'h8
`define OP_CLK_ON 4'h9
`define OP_CLK_OFF 4'hA
`define OP_RST_REL 4'hB
`define OP_SRST_ON 4'hC
`define OP_SRST_OFF 4'hD
`define OP_END 4'hE

`endif

// File: inc/ddr_init_host_pkg.sv
// Purpose: Types shared by the host design.
// Assumes: Nothing beyond the parameter header.
// Notes: State encoding left to the tool.
package ddr_init_host_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXEC,
		ST_ACCESS,
		ST_WAIT
	} seq_state_t;
endpackage : ddr_init_host_pkg

// File: hdl/ddr_init_host.sv
// Purpose: Host sequencer bringing a DDR controller up, down and back.
// Assumes: Device bus and this block share clk_i; pins are asynchronous.
// Notes: Software orders a sequence over APB and watches STATUS.
`timescale 1ns/1ps
`include "ddr_init_host_params.svh"

////////////////////////////////////////////////////////////////////////////
module ddr_init_host
	import ddr_init_host_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Software APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [5:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Device APB master
	output logic m_psel_o,
	output logic m_penable_o,
	output logic m_pwrite_o,
	output logic [11:0] m_paddr_o,
	output logic [31:0] m_pwdata_o,
	input wire logic [31:0] m_prdata_i,
	input wire logic m_pready_i,
	// System clock and reset control
	output logic pll_run_o,
	input wire logic pll_stable_i,
	output logic mod_clk_en_o,
	output logic dev_rst_n_o,
	output logic sync_reset_o,
	input wire logic cal_clk_i,
	input wire logic line_trap_i
);

////////////////////////////////////////////////////////////////////////////
// Synchronisers

logic pll_m_q, pll_s_q;
logic trap_m_q, trap_s_q;
logic cal_m_q, cal_s_q, cal_p_q;

always_ff @(posedge clk_i) begin
	if (!nrst_i) begin
		pll_m_q <= 1'b0;
		pll_s_q <= 1'b0;
		trap_m_q <= 1'b0;
		trap_s_q <= 1'b0;
		cal_m_q <= 1'b0;
		cal_s_q <= 1'b0;
		cal_p_q <= 1'b0;
	end else if (ce_i) begin
		pll_m_q <= pll_stable_i;
		pll_s_q <= pll_m_q;
		trap_m_q <= line_trap_i;
		trap_s_q <= trap_m_q;
		cal_m_q <= cal_clk_i;
		cal_s_q <= cal_m_q;
		cal_p_q <= cal_s_q;
	end
end

wire logic cal_rise = cal_s_q & ~cal_p_q;

////////////////////////////////////////////////////////////////////////////
// Software registers

logic [31:0] phy_cfg_q, mem_cfg_q, mem_cfg2_q, tim1_q, tim2_q;
logic [31:0] ref_int_q, prio_q;
logic mddr_q, init_done_q, stopped_q;
logic s_ready_q, s_err_q;
logic [31:0] s_rdata_q;
seq_state_t state_q;
logic [5:0] pc_q;

wire logic s_access = psel_i & penable_i;
wire logic s_wr = s_access & pwrite_i & s_ready_q;
wire logic s_mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= `REG_PRIO);
wire logic idle = (state_q == ST_IDLE);
wire logic go_init = s_wr && paddr_i == `REG_CTRL && pwdata_i[`CTRL_INIT]
	&& idle;
wire logic go_stop = s_wr && paddr_i == `REG_CTRL && pwdata_i[`CTRL_STOP]
	&& idle && init_done_q && !stopped_q && !go_init;
wire logic go_restart = s_wr && paddr_i == `REG_CTRL
	&& pwdata_i[`CTRL_RESTART] && idle && stopped_q && !go_init;
wire logic [31:0] status_w = {18'h0, pc_q, 4'h0, trap_s_q, stopped_q,
	init_done_q, ~idle};

logic [31:0] rd_mux;
always_comb begin
	case (paddr_i)
	`REG_CTRL: rd_mux = {28'h0, mddr_q, 3'h0};
	`REG_STATUS: rd_mux = status_w;
	`REG_PHY_CFG: rd_mux = phy_cfg_q;
	`REG_MEM_CFG: rd_mux = mem_cfg_q;
	`REG_MEM_CFG2: rd_mux = mem_cfg2_q;
	`REG_TIM1: rd_mux = tim1_q;
	`REG_TIM2: rd_mux = tim2_q;
	`REG_REF_INT: rd_mux = ref_int_q;
	`REG_PRIO: rd_mux = prio_q;
	default: rd_mux = 32'h0000_0000;
	endcase
end

// One wait cycle: pready rises in the second access cycle
always_ff @(posedge clk_i) begin
	if (!nrst_i) begin
		s_ready_q <= 1'b0;
		s_err_q <= 1'b0;
		s_rdata_q <= 32'h0000_0000;
	end else if (ce_i) begin
		s_ready_q <= s_access & ~s_ready_q;
		s_err_q <= s_access & ~s_ready_q & ~s_mapped;
		s_rdata_q <= (s_access & ~s_ready_q & ~pwrite_i) ? rd_mux
			: 32'h0000_0000;
	end
end

always_ff @(posedge clk_i) begin
	if (!nrst_i) begin
		phy_cfg_q <= 32'h0000_0000;
		mem_cfg_q <= 32'h0000_0000;
		mem_cfg2_q <= 32'h0000_0000;
		tim1_q <= 32'h0000_0000;
		tim2_q <= 32'h0000_0000;
		ref_int_q <= 32'h0000_0000;
		prio_q <= `PRIO_RESET;
		mddr_q <= 1'b0;
	end else if (ce_i && s_wr) begin
		case (paddr_i)
		`REG_CTRL: mddr_q <= pwdata_i[`CTRL_MDDR];
		`REG_PHY_CFG: phy_cfg_q <= pwdata_i;
		`REG_MEM_CFG: mem_cfg_q <= pwdata_i;
		`REG_MEM_CFG2: mem_cfg2_q <= pwdata_i;
		`REG_TIM1: tim1_q <= pwdata_i;
		`REG_TIM2: tim2_q <= pwdata_i;
		`REG_REF_INT: ref_int_q <= pwdata_i;
		`REG_PRIO: prio_q <= pwdata_i;
		default: mddr_q <= mddr_q;
		endcase
	end
end

assign prdata_o = s_rdata_q;
assign pready_o = s_ready_q;
assign pslverr_o = s_err_q;

////////////////////////////////////////////////////////////////////////////
// Sequence program

logic [3:0] op;
logic [11:0] op_addr;
logic [31:0] op_data;
wire logic [31:0] rr = ref_int_q & `REF_INTERVAL;
wire logic [31:0] cfg_base = mem_cfg_q
	& ~(`CFG_BOOT_UNLOCK | `CFG_TIM_UNLOCK);
wire logic [31:0] slew_w = mddr_q ? (`SLEW_PULLDOWN | `SLEW_LEVEL)
	: 32'h0000_0000;
wire logic [31:0] cal_lock = `CAL_CLK_RESET | `CAL_FREEZE;

always_comb begin
	op = `OP_END;
	op_addr = `DEV_CAL_CTL;
	op_data = 32'h0000_0000;
	case (pc_q)
	6'h00: op = `OP_PLL_ON;
	6'h01: op = `OP_WAIT_PLL;
	6'h02: op = `OP_CLK_ON;
	6'h03: op = `OP_RST_REL;
	6'h04: begin op = `OP_WR; op_data = `CAL_FREEZE; end
	6'h05: op = `OP_WR;
	6'h06: begin op = `OP_WR; op_data = `CAL_CLK_RESET; end
	6'h07: op = `OP_WAIT_CAL;
	6'h08: op = `OP_WR;
	6'h09: op = `OP_WAIT_CAL;
	6'h0A: begin op = `OP_WR; op_data = `CAL_CLK_RESET; end
	6'h0B: begin op = `OP_POLL1; op_data = `CAL_READY; end
	6'h0C: begin op = `OP_WR; op_data = cal_lock; end
	6'h0D: begin op = `OP_WR; op_data = cal_lock | `CAL_SLEEP; end
	6'h0E: begin
		op = `OP_WR;
		op_data = cal_lock | `CAL_SLEEP | `CAL_RX_SAVE;
	end
	6'h0F: begin
		op = `OP_WR;
		op_addr = `DEV_PHY_CTL;
		op_data = phy_cfg_q;
	end
	6'h10: begin op = `OP_WR; op_addr = `DEV_SLEW; op_data = slew_w; end
	6'h11: begin
		op = `OP_WR;
		op_addr = `DEV_MEM_CFG;
		op_data = cfg_base | `CFG_BOOT_UNLOCK;
	end
	6'h12: begin
		op = `OP_WR;
		op_addr = `DEV_MEM_CFG;
		op_data = cfg_base | `CFG_TIM_UNLOCK;
	end
	6'h13: begin
		op = `OP_WRM;
		op_addr = `DEV_MEM_CFG2;
		op_data = mem_cfg2_q;
	end
	6'h14: begin op = `OP_WR; op_addr = `DEV_TIMING1; op_data = tim1_q; end
	6'h15: begin op = `OP_WR; op_addr = `DEV_TIMING2; op_data = tim2_q; end
	6'h16: begin op = `OP_WR; op_addr = `DEV_MEM_CFG; op_data = cfg_base; end
	6'h17: begin
		op = `OP_WR;
		op_addr = `DEV_REFRESH;
		op_data = `REF_LOW_POWER | `REF_CLK_STOP | rr;
	end
	6'h18: op = `OP_SRST_ON;
	6'h19: op = `OP_SRST_OFF;
	6'h1A: begin op = `OP_WR; op_addr = `DEV_REFRESH; op_data = rr; end
	6'h1B: begin
		op = `OP_WR;
		op_addr = `DEV_PRIORITY;
		op_data = prio_q;
	end
	6'h1C: op = `OP_END;
	6'h1D: begin
		op = `OP_WR;
		op_addr = `DEV_REFRESH;
		op_data = `REF_LOW_POWER | rr;
	end
	6'h1E: begin
		op = `OP_WR;
		op_addr = `DEV_REFRESH;
		op_data = `REF_LOW_POWER | `REF_CLK_STOP | rr;
	end
	6'h1F: op = `OP_WAIT_CYC;
	6'h20: op = `OP_CLK_OFF;
	6'h21: op = `OP_PLL_OFF;
	6'h22: op = `OP_END;
	6'h23: op = `OP_PLL_ON;
	6'h24: op = `OP_WAIT_PLL;
	6'h25: op = `OP_CLK_ON;
	6'h26: begin
		op = `OP_WR;
		op_addr = `DEV_PHY_RST;
		op_data = `PHY_SOFT_RESET;
	end
	6'h27: begin
		op = `OP_POLL0;
		op_addr = `DEV_PHY_RST;
		op_data = `PHY_SOFT_RESET;
	end
	6'h28: begin
		op = `OP_WR;
		op_addr = `DEV_REFRESH;
		op_data = `REF_LOW_POWER | rr;
	end
	6'h29: begin op = `OP_WR; op_addr = `DEV_REFRESH; op_data = rr; end
	default: op = `OP_END;
	endcase
end

////////////////////////////////////////////////////////////////////////////
// Sequencer and device bus master

logic [7:0] wait_q;
wire logic is_bus = (op == `OP_WR) || (op == `OP_POLL1)
	|| (op == `OP_POLL0) || (op == `OP_WRM && mddr_q);
wire logic is_poll = (op == `OP_POLL1) || (op == `OP_POLL0);
wire logic m_done = m_psel_o & m_penable_o & m_pready_i;
wire logic poll_ok = (op == `OP_POLL1) ? ((m_prdata_i & op_data) != 0)
	: ((m_prdata_i & op_data) == 0);
wire logic wait_ok = (op == `OP_WAIT_PLL) ? pll_s_q
	: (op == `OP_WAIT_CAL) ? (wait_q[1:0] == `CAL_EDGES)
	: (wait_q == 8'(`CLK_STOP_CYCLES));
wire logic [5:0] pc_inc = pc_q + 6'h01;

always_ff @(posedge clk_i) begin
	if (!nrst_i) begin
		state_q <= ST_IDLE;
		pc_q <= `PC_INIT;
		wait_q <= 8'h00;
		m_psel_o <= 1'b0;
		m_penable_o <= 1'b0;
		m_pwrite_o <= 1'b0;
		m_paddr_o <= 12'h000;
		m_pwdata_o <= 32'h0000_0000;
		init_done_q <= 1'b0;
		stopped_q <= 1'b0;
	end else if (ce_i) begin
		case (state_q)
		ST_IDLE: begin
			if (go_init) begin
				pc_q <= `PC_INIT;
				init_done_q <= 1'b0;
				stopped_q <= 1'b0;
				state_q <= ST_EXEC;
			end else if (go_stop) begin
				pc_q <= `PC_STOP;
				state_q <= ST_EXEC;
			end else if (go_restart) begin
				pc_q <= `PC_RESTART;
				state_q <= ST_EXEC;
			end
		end
		ST_EXEC: begin
			wait_q <= 8'h00;
			if (is_bus) begin
				// Setup cycle of the device transfer
				m_psel_o <= 1'b1;
				m_pwrite_o <= ~is_poll;
				m_paddr_o <= op_addr;
				m_pwdata_o <= is_poll ? 32'h0000_0000 : op_data;
				state_q <= ST_ACCESS;
			end else if (op == `OP_WAIT_PLL || op == `OP_WAIT_CAL
				|| op == `OP_WAIT_CYC) begin
				state_q <= ST_WAIT;
			end else if (op == `OP_END) begin
				init_done_q <= (pc_q == 6'h1C) | init_done_q;
				stopped_q <= (pc_q == 6'h22);
				state_q <= ST_IDLE;
			end else begin
				pc_q <= pc_inc;
			end
		end
		ST_ACCESS: begin
			m_penable_o <= 1'b1;
			if (m_done) begin
				m_psel_o <= 1'b0;
				m_penable_o <= 1'b0;
				state_q <= ST_EXEC;
				// A failed poll reissues the same read
				if (!is_poll || poll_ok) begin
					pc_q <= pc_inc;
				end
			end
		end
		ST_WAIT: begin
			if (wait_ok) begin
				pc_q <= pc_inc;
				state_q <= ST_EXEC;
			end else if (op == `OP_WAIT_CYC
				|| (op == `OP_WAIT_CAL && cal_rise)) begin
				wait_q <= wait_q + 8'h01;
			end
		end
		default: state_q <= ST_IDLE;
		endcase
	end
end

// Clock and reset controls follow the program's simple ops
wire logic in_exec = (state_q == ST_EXEC) && ce_i;
always_ff @(posedge clk_i) begin
	if (!nrst_i) begin
		pll_run_o <= 1'b0;
		mod_clk_en_o <= 1'b0;
		dev_rst_n_o <= 1'b0;
		sync_reset_o <= 1'b0;
	end else if (in_exec) begin
		if (op == `OP_PLL_ON) pll_run_o <= 1'b1;
		if (op == `OP_PLL_OFF) pll_run_o <= 1'b0;
		if (op == `OP_CLK_ON) mod_clk_en_o <= 1'b1;
		if (op == `OP_CLK_OFF) mod_clk_en_o <= 1'b0;
		if (op == `OP_RST_REL) dev_rst_n_o <= 1'b1;
		if (op == `OP_SRST_ON) sync_reset_o <= 1'b1;
		if (op == `OP_SRST_OFF) sync_reset_o <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////
// Checks

logic [31:0] ref_shadow_q, cfg_shadow_q;
logic ready_seen_q;
logic [7:0] stop_age_q;
wire logic m_wr_done = m_done & m_pwrite_o;

always_ff @(posedge clk_i) begin
	if (!nrst_i) begin
		ref_shadow_q <= 32'h0000_0000;
		cfg_shadow_q <= 32'h0000_0000;
		ready_seen_q <= 1'b0;
		stop_age_q <= 8'h00;
	end else if (ce_i) begin
		if (m_wr_done && m_paddr_o == `DEV_REFRESH)
			ref_shadow_q <= m_pwdata_o;
		if (m_wr_done && m_paddr_o == `DEV_MEM_CFG)
			cfg_shadow_q <= m_pwdata_o;
		if (go_init)
			ready_seen_q <= 1'b0;
		else if (m_done && !m_pwrite_o && m_paddr_o == `DEV_CAL_CTL
			&& (m_prdata_i & `CAL_READY) != 0)
			ready_seen_q <= 1'b1;
		if (m_wr_done && m_paddr_o == `DEV_REFRESH)
			stop_age_q <= 8'h00;
		else if (stop_age_q != 8'hFF)
			stop_age_q <= stop_age_q + 8'h01;
	end
end

sequence s_setup;
	m_psel_o && !m_penable_o;
endsequence

sequence s_held;
	m_psel_o && m_penable_o && !m_pready_i;
endsequence

AST_RST_AFTER_CLOCKS: assert property (@(posedge clk_i)
	disable iff (!nrst_i)
	$rose(dev_rst_n_o) |-> pll_run_o && mod_clk_en_o)
	else $error("controller reset released before clocks ran");

AST_SETUP_ACCESS: assert property (@(posedge clk_i) disable iff (!nrst_i)
	s_setup ##1 ce_i |-> m_psel_o && m_penable_o)
	else $error("setup cycle not followed by access phase");

AST_HOLD_REQUEST: assert property (@(posedge clk_i) disable iff (!nrst_i)
	s_held |=> $stable(m_paddr_o) && $stable(m_pwdata_o)
		&& $stable(m_pwrite_o) && m_psel_o)
	else $error("device request changed before it was taken");

AST_FREEZE_AFTER_READY: assert property (@(posedge clk_i)
	disable iff (!nrst_i)
	m_wr_done && m_paddr_o == `DEV_CAL_CTL
		&& (m_pwdata_o & `CAL_FREEZE) != 0
		&& (m_pwdata_o & `CAL_CLK_RESET) != 0 |-> ready_seen_q)
	else $error("calibration frozen before ready was seen");

AST_TIMING_UNLOCKED: assert property (@(posedge clk_i)
	disable iff (!nrst_i)
	m_wr_done && (m_paddr_o == `DEV_TIMING1 || m_paddr_o == `DEV_TIMING2)
	|-> (cfg_shadow_q & `CFG_TIM_UNLOCK) != 0
		&& (cfg_shadow_q & `CFG_BOOT_UNLOCK) == 0)
	else $error("timing written while locked");

AST_SYNC_RESET_STATE: assert property (@(posedge clk_i)
	disable iff (!nrst_i)
	$rose(sync_reset_o) |-> (ref_shadow_q & `REF_LOW_POWER) != 0
		&& (ref_shadow_q & `REF_CLK_STOP) != 0
		&& (ref_shadow_q & `REF_SELFREFRESH_OR_POWERDOWN_SELECT) == 0)
	else $error("module reset without self-refresh programmed");

AST_STOP_WAIT: assert property (@(posedge clk_i)
	disable iff (!nrst_i)
	$fell(mod_clk_en_o) |-> stop_age_q >= 8'(`CLK_STOP_CYCLES))
	else $error("interface clock gated too soon after clock stop");

AST_GATE_SELF_REFRESH: assert property (@(posedge clk_i)
	disable iff (!nrst_i)
	$fell(mod_clk_en_o) |-> (ref_shadow_q & `REF_LOW_POWER) != 0
		&& (ref_shadow_q & `REF_SELFREFRESH_OR_POWERDOWN_SELECT) == 0)
	else $error("clock gated outside self-refresh");

AST_RESTART_ORDER: assert property (@(posedge clk_i)
	disable iff (!nrst_i)
	$rose(mod_clk_en_o) |-> pll_run_o && pll_s_q)
	else $error("interface clock enabled before core clock stable");

endmodule : ddr_init_host

// File: dv/ddr_dev_model.sv
// Purpose: Behavioural memory controller that the init host drives.
// Assumes: APB slave on clk_i; word registers at offsets 0 to 9.
// Notes: Keeps a write log for the bench; slow_i adds wait states.
`timescale 1ns/1ps
`include "ddr_init_host_params.svh"
module ddr_dev_model #(
	parameter int RST_READS = 3,
	parameter int CAL_DLY = 4
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	input wire logic slow_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic pll_i,
	input wire logic srst_i,
	input wire logic cal_clk_i,
	input wire logic trap_i,
	output logic line_trap_o
);
	logic [31:0] regs [16];
	logic [43:0] log_q [$];
	logic [31:0] rd_q;
	logic rdy_q, cal_ready, trap_q, cc1, cc2, rx_off, mclk_on;
	int cnt, cal_st, edges, rdy_cnt, rst_reads, viol, srst_pos;
	wire [3:0] idx = paddr_i[5:2];
	wire [31:0] d = pwdata_i;
	wire acc = psel_i && penable_i;
	// Access to any register but register 0 before calibration is done hangs the bus
	wire locked = !cal_ready && idx != 4'h0;
	wire [31:0] rdv = (idx == 4'h0 && cal_ready) ?
		regs[0] | `CAL_READY : regs[idx];
	wire wt = cnt >= (slow_i ? 5 : 0);
	assign pready_o = rdy_q;
	assign prdata_o = rd_q;
	assign line_trap_o = trap_q;
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		cc1 <= cal_clk_i;
		cc2 <= cc1;
		if (!nrst_i) begin
			foreach (regs[i]) regs[i] <= 32'h0;
			regs[0] <= `CAL_SLEEP | `CAL_FREEZE;
			rd_q <= 32'h0;
			{rdy_q, cal_ready, trap_q, rx_off, mclk_on} <= 5'h00;
			{cnt, cal_st, edges, rdy_cnt, rst_reads, viol} <= '0;
			srst_pos <= -1;
			log_q.delete();
		end else begin
			if (cc1 && !cc2) edges <= edges + 1;
			if (trap_i) trap_q <= 1'b1;
			// Receivers stay off after a write until a read needs them
			if (acc) rx_off <= pwrite_i;
			// Memory clock stops when allowed; any access restarts it
			if (acc) mclk_on <= 1'b1;
			else if ((regs[7] & `REF_CLK_STOP) != 0) mclk_on <= 1'b0;
			if (srst_i) srst_pos <= log_q.size();
			if (cal_st == 3 && !cal_ready) rdy_cnt <= rdy_cnt + 1;
			// Result stays once ready; freeze only stops updates
			if (rdy_cnt == CAL_DLY) cal_ready <= 1'b1;
			if (acc && !rdy_q && !locked && wt) begin
				rdy_q <= 1'b1;
				rd_q <= rdv;
			end else begin
				rdy_q <= 1'b0;
				// Released data bus never keeps the last value
				rd_q <= ~rd_q;
				cnt <= (acc && !rdy_q) ? cnt + 1 : 0;
			end
			if (acc && rdy_q) begin
				if (!rst_n_i || !clk_en_i || !pll_i) viol <= viol + 1;
				if (pwrite_i) begin
					log_q.push_back({paddr_i, d});
					regs[idx] <= d;
					if (idx == 4'h9) rst_reads <= 0;
				end else if (idx == 4'h9 && regs[9][10]) begin
					rst_reads <= rst_reads + 1;
					if (rst_reads == RST_READS - 1) regs[9] <= 32'h0;
				end
				if (pwrite_i && idx == 4'h0) begin
					if (!cal_ready && d[1] && cal_st != 0) viol <= viol + 1;
					if (cal_st == 0 && d[2:0] == 3'b100) cal_st <= 1;
					if (cal_st == 1 && !d[2]) cal_st <= 2;
					if (cal_st == 2 && d[2]) cal_st <= 3;
					// Each clock-reset level must span a calibration clock
					if (cal_st inside {1, 2} && edges < 1) viol <= viol + 1;
					edges <= 0;
				end
			end
		end
	end
endmodule : ddr_dev_model

// File: dv/tb_top.sv
// Purpose: Self-checking bench for the DDR init host.
// Assumes: Device model answers on the same clock.
// Notes: Scenarios run in order; t_basic and each t_init start from their own reset.
`timescale 1ns/1ps
`include "ddr_init_host_params.svh"
module tb_top;
	localparam logic [31:0] PHY = 32'h0000_00C5;
	localparam logic [31:0] CFG = 32'h0000_4632;
	localparam logic [31:0] CFG2 = 32'h0000_0003;
	localparam logic [31:0] T1 = 32'h1234_5678;
	localparam logic [31:0] T2 = 32'h0ABC_DEF0;
	localparam logic [31:0] RR = 32'h0000_0492;
	localparam logic [31:0] PRIO = 32'h0000_0030;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [5:0] paddr = 6'h00;
	logic [31:0] pwdata = 32'h0;
	logic pll_stable = 1'b0, trap = 1'b0, slow = 1'b0, cal_clk = 1'b0;
	wire [31:0] prdata, m_prdata, m_pwdata;
	wire [11:0] m_paddr;
	wire pready, pslverr, m_psel, m_penable, m_pwrite, m_pready;
	wire pll_run, mod_clk_en, dev_rst_n, sync_reset, line_trap;
	int err_count = 0, checks = 0, cyc = 0, t_wr = 0, t_off = 0;
	logic en_prev = 1'b0;
	always #2 clk_i = ~clk_i;
	initial begin
		#5;
		forever #16 cal_clk = ~cal_clk;
	end
	ddr_init_host i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .m_psel_o(m_psel),
		.m_penable_o(m_penable), .m_pwrite_o(m_pwrite), .m_paddr_o(m_paddr),
		.m_pwdata_o(m_pwdata), .m_prdata_i(m_prdata), .m_pready_i(m_pready),
		.pll_run_o(pll_run), .pll_stable_i(pll_stable),
		.mod_clk_en_o(mod_clk_en), .dev_rst_n_o(dev_rst_n),
		.sync_reset_o(sync_reset), .cal_clk_i(cal_clk),
		.line_trap_i(line_trap));
	ddr_dev_model i_dev (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(m_psel),
		.penable_i(m_penable), .pwrite_i(m_pwrite), .paddr_i(m_paddr),
		.pwdata_i(m_pwdata), .prdata_o(m_prdata), .pready_o(m_pready),
		.slow_i(slow), .rst_n_i(dev_rst_n), .clk_en_i(mod_clk_en),
		.pll_i(pll_run), .srst_i(sync_reset), .cal_clk_i(cal_clk),
		.trap_i(trap), .line_trap_o(line_trap));
	// Clock-stop write and clock gating moments, in cycles
	always @(posedge clk_i) begin
		cyc++;
		if (m_psel && m_penable && m_pready && m_pwrite &&
			m_paddr == `DEV_REFRESH && m_pwdata[30]) t_wr = cyc;
		if (en_prev && !mod_clk_en) t_off = cyc;
		en_prev = mod_clk_en;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [43:0] e,
		input logic [43:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 100);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100) chk("slave answer", 1, 0);
	endtask : apb
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask : rd
	task automatic wait_idle;
		logic [31:0] r;
		int n;
		n = 0;
		do begin
			rd(`REG_STATUS, r);
			n++;
		end while (r[0] !== 1'b0 && n < 3000);
		if (n >= 3000) chk("busy cleared", 0, 1);
	endtask : wait_idle
	task automatic do_reset(input logic s);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		pll_stable <= 1'b0;
		slow <= s;
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
	endtask : do_reset
	task automatic chk_log(input logic [43:0] e[$], input int st);
		chk("write count", 44'(e.size() + st), 44'(i_dev.log_q.size()));
		foreach (e[i]) chk("device write", e[i], i_dev.log_q[st + i]);
	endtask : chk_log
	////////////////////////////////////////////////////////////////////////
	task automatic t_basic;
		logic [31:0] r;
		logic e;
		do_reset(1'b0);
		chk("outputs after reset", 0,
			{pll_run, mod_clk_en, dev_rst_n, sync_reset, m_psel});
		rd(`REG_PRIO, r);
		chk("priority reset", `PRIO_RESET, r);
		apb(1'b0, 6'h24, 32'h0, r, e);
		chk("unmapped error", 1, e);
		chk("unmapped data", 0, r);
		wr(`REG_CTRL, 32'h2);
		rd(`REG_STATUS, r);
		chk("stop before init", 0, r[2:0]);
		chk("device idle", 0, 44'(i_dev.log_q.size()));
	endtask : t_basic
	task automatic t_init(input logic m, input logic s);
		logic [31:0] cw [8] = '{32'h2, 32'h0, 32'h4, 32'h0, 32'h4, 32'h6,
			32'h7, 32'hF};
		logic [43:0] e[$];
		logic [31:0] r;
		int sp;
		do_reset(s);
		wr(`REG_PHY_CFG, PHY);
		wr(`REG_MEM_CFG, CFG);
		wr(`REG_MEM_CFG2, CFG2);
		wr(`REG_TIM1, T1);
		wr(`REG_TIM2, T2);
		wr(`REG_REF_INT, RR);
		wr(`REG_PRIO, PRIO);
		wr(`REG_CTRL, {28'h0, m, 3'b001});
		repeat (20) @(posedge clk_i);
		chk("clocks before lock", 3'b100, {pll_run, mod_clk_en, dev_rst_n});
		pll_stable <= 1'b1;
		wait_idle();
		foreach (cw[i]) e.push_back({`DEV_CAL_CTL, cw[i]});
		e.push_back({`DEV_PHY_CTL, PHY});
		e.push_back({`DEV_SLEW, m ? `SLEW_PULLDOWN | `SLEW_LEVEL : 32'h0});
		e.push_back({`DEV_MEM_CFG, CFG | `CFG_BOOT_UNLOCK});
		e.push_back({`DEV_MEM_CFG, CFG | `CFG_TIM_UNLOCK});
		if (m) e.push_back({`DEV_MEM_CFG2, CFG2});
		e.push_back({`DEV_TIMING1, T1});
		e.push_back({`DEV_TIMING2, T2});
		e.push_back({`DEV_MEM_CFG, CFG});
		e.push_back({`DEV_REFRESH, `REF_LOW_POWER | `REF_CLK_STOP | RR});
		sp = e.size();
		e.push_back({`DEV_REFRESH, RR});
		e.push_back({`DEV_PRIORITY, PRIO});
		chk_log(e, 0);
		chk("reset position", 44'(sp), 44'(i_dev.srst_pos));
		chk("device faults", 0, 44'(i_dev.viol));
		rd(`REG_STATUS, r);
		chk("status after init", 3'b010, r[2:0]);
		chk("clocks after init", 3'b111, {pll_run, mod_clk_en, dev_rst_n});
		chk("receivers off", 1, i_dev.rx_off);
	endtask : t_init
	task automatic t_trap;
		logic [31:0] r;
		rd(`REG_STATUS, r);
		chk("trap idle", 0, r[3]);
		trap <= 1'b1;
		@(posedge clk_i);
		trap <= 1'b0;
		repeat (8) @(posedge clk_i);
		rd(`REG_STATUS, r);
		chk("trap seen", 1, r[3]);
	endtask : t_trap
	task automatic t_stop_restart;
		logic [43:0] e[$];
		logic [31:0] r;
		int l;
		l = i_dev.log_q.size();
		wr(`REG_CTRL, 32'h2);
		wait_idle();
		e.push_back({`DEV_REFRESH, `REF_LOW_POWER | RR});
		e.push_back({`DEV_REFRESH, `REF_LOW_POWER | `REF_CLK_STOP | RR});
		chk_log(e, l);
		chk("stop wait", 1, 44'(t_off - t_wr >= `CLK_STOP_CYCLES));
		rd(`REG_STATUS, r);
		chk("stopped", 3'b110, r[2:0]);
		chk("clocks gated", 0, {pll_run, mod_clk_en});
		chk("memory clock stopped", 0, i_dev.mclk_on);
		pll_stable <= 1'b0;
		wr(`REG_CTRL, 32'h4);
		repeat (20) @(posedge clk_i);
		chk("clock before stable", 2'b10, {pll_run, mod_clk_en});
		pll_stable <= 1'b1;
		wait_idle();
		e.delete();
		e.push_back({`DEV_PHY_RST, `PHY_SOFT_RESET});
		e.push_back({`DEV_REFRESH, `REF_LOW_POWER | RR});
		e.push_back({`DEV_REFRESH, RR});
		chk_log(e, l + 2);
		chk("reset polls", 3, 44'(i_dev.rst_reads));
		rd(`REG_STATUS, r);
		chk("restarted", 3'b010, r[2:0]);
		chk("memory clock running", 1, i_dev.mclk_on);
		chk("device faults", 0, 44'(i_dev.viol));
	endtask : t_stop_restart
	////////////////////////////////////////////////////////////////////////
	initial begin
		t_basic();
		t_init(1'b0, 1'b0);
		t_trap();
		t_init(1'b1, 1'b1);
		t_stop_restart();
		conclude();
	end
	// A hang ends the run, with a limit well after any real scenario would end
	initial begin
		repeat (60000) @(posedge clk_i);
		err_count++;
		conclude();
	end
endmodule : tb_top
